/* src/vic_pkg.sv */
// Package: constants and types for the vectored interrupt controller
package vic_pkg;

	// ------------------------------------------------------------
	// Register map (word offsets = byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_VTBASE = 12'h008;
	localparam logic [11:0] OFS_SEL = 12'h00c;
	localparam logic [11:0] OFS_SRC_CFG = 12'h010;
	localparam logic [11:0] OFS_PEND_SET = 12'h014;
	localparam logic [11:0] OFS_PEND_CLR = 12'h018;
	localparam logic [11:0] OFS_ACTIVE = 12'h01c;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CTRL_GMASK_BIT = 0;
	localparam int CTRL_ALTMAP_BIT = 1;
	localparam int CTRL_TBLSRAM_BIT = 2;
	localparam int CTRL_GROUP_LSB = 4;
	localparam int SRCCFG_EN_BIT = 8;
	localparam int PRIO_BITS = 3;
	localparam int PRIO_FIELD = 8;
	localparam logic [2:0] PRIO_IDLE = 3'h7;
	localparam logic [31:0] VTBASE_RST = 32'h00000000;
	localparam logic [31:0] VTBASE_ALIGN_MASK = 32'hfffffc00;
	localparam logic [1:0] GROUP_RST = 2'h0;
	localparam logic [3:0] FETCH_CYC = 4'h2;
	localparam logic [3:0] STACK_CYC = 4'h4;
	localparam int ALT_STRIDE_SHIFT = 0;
	localparam int STD_STRIDE_SHIFT = 1;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_STACK = 4'b0010,
		ST_FETCH = 4'b0100,
		ST_RUN = 4'b1000
	} vic_state_t;

	typedef struct packed {
		logic gmask;
		logic altmap;
		logic tbl_sram;
		logic [1:0] sub_bits;
	} vic_ctrl_t;

	typedef struct packed {
		logic valid;
		logic [7:0] id;
		logic [2:0] prio;
	} vic_cand_t;

endpackage : vic_pkg

/* src/vic_ctrl.sv */
// Module: vectored nested priority interrupt controller core
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module vic_ctrl #(
	parameter int NSRC = 163,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [NSRC-1:0] irq_src,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic cpu_irq_req,
	output logic [31:0] cpu_vector,
	output logic [7:0] cpu_irq_id,
	input wire logic cpu_irq_ack,
	input wire logic cpu_eoi,
	output logic cpu_in_handler,
	output logic cpu_stack_go
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_m_reg;
	logic rst_n_reg;
	// Two stages so release is clean relative to clk_sys
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_m_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_m_reg <= 1'b1;
			rst_n_reg <= rst_m_reg;
		end
	end

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Preemption part of a priority under the current group split
	function automatic logic [2:0] preempt_of(input logic [2:0] p,
		input logic [1:0] sb);
		preempt_of = p & (3'h7 << sb);
	endfunction : preempt_of

	// Vector slot offset; compressed map packs slots at word stride
	function automatic logic [31:0] slot_ofs(input logic [7:0] id,
		input logic alt);
		logic [31:0] w;
		w = {24'h000000, id} + 32'h00000010;
		slot_ofs = alt ? (w << (2 + vic_pkg::ALT_STRIDE_SHIFT))
			: (w << (2 + vic_pkg::STD_STRIDE_SHIFT));
	endfunction : slot_ofs

	// ------------------------------------------------------------
	// Configuration and per-source state
	// ------------------------------------------------------------
	vic_pkg::vic_ctrl_t ctrl_reg, ctrl_next;
	logic [31:0] vtbase_reg, vtbase_next;
	logic [7:0] sel_reg, sel_next;
	logic [NSRC-1:0] en_reg, en_next;
	logic [NSRC-1:0] pend_reg, pend_next;
	logic [NSRC-1:0] act_reg, act_next;
	logic [NSRC-1:0] src_d_reg, src_d_next;
	logic [2:0] prio_reg [NSRC];
	logic [2:0] prio_next [NSRC];

	// ------------------------------------------------------------
	// Dispatch and nesting state
	// ------------------------------------------------------------
	vic_pkg::vic_state_t st_reg, st_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] cur_id_reg, cur_id_next;
	logic [7:0] stk_id_reg [DEPTH];
	logic [7:0] stk_id_next [DEPTH];
	logic [2:0] stk_pr_reg [DEPTH];
	logic [2:0] stk_pr_next [DEPTH];
	logic [3:0] depth_reg, depth_next;
	logic [2:0] run_pr_reg, run_pr_next;
	logic req_reg, req_next;
	logic [31:0] vec_reg, vec_next;
	logic [31:0] rdata_reg, rdata_next;
	logic stack_go_reg, stack_go_next;
	logic in_h_reg, in_h_next;

	// ------------------------------------------------------------
	// Arbitration
	// ------------------------------------------------------------
	vic_pkg::vic_cand_t win;
	logic can_preempt;
	// Strict less-than scan keeps the lower number on ties
	always_comb begin
		win = '0;
		win.prio = vic_pkg::PRIO_IDLE;
		for (int i = 0; i < NSRC; i++) begin
			if (pend_reg[i] && en_reg[i] && !act_reg[i]) begin
				if (!win.valid || prio_reg[i] < win.prio) begin
					win.valid = 1'b1;
					win.id = 8'(i);
					win.prio = prio_reg[i];
				end
			end
		end
		// Only the preemption group is compared
		can_preempt = win.valid && (depth_reg == 4'h0 ||
			preempt_of(win.prio, ctrl_reg.sub_bits) <
			preempt_of(run_pr_reg, ctrl_reg.sub_bits));
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic take;
	always_comb begin
		ctrl_next = ctrl_reg;
		vtbase_next = vtbase_reg;
		sel_next = sel_reg;
		en_next = en_reg;
		act_next = act_reg;
		prio_next = prio_reg;
		src_d_next = irq_src;
		st_next = st_reg;
		cnt_next = cnt_reg;
		cur_id_next = cur_id_reg;
		stk_id_next = stk_id_reg;
		stk_pr_next = stk_pr_reg;
		depth_next = depth_reg;
		run_pr_next = run_pr_reg;
		req_next = req_reg;
		vec_next = vec_reg;
		stack_go_next = 1'b0;
		rdata_next = 32'h00000000;
		take = 1'b0;
		pend_next = pend_reg;

		// Software side effects first, so hardware sets win later
		if (reg_wr) begin
			if (reg_addr == vic_pkg::OFS_CTRL) begin
				// Global mask bit is separate from en_reg
				ctrl_next.gmask = reg_wdata[vic_pkg::CTRL_GMASK_BIT];
				ctrl_next.altmap = reg_wdata[vic_pkg::CTRL_ALTMAP_BIT];
				ctrl_next.tbl_sram = reg_wdata[vic_pkg::CTRL_TBLSRAM_BIT];
				ctrl_next.sub_bits = reg_wdata[vic_pkg::CTRL_GROUP_LSB +: 2];
			end else if (reg_addr == vic_pkg::OFS_VTBASE) begin
				// Low bits dropped: table must sit on 1 kB
				vtbase_next = reg_wdata & vic_pkg::VTBASE_ALIGN_MASK;
			end else if (reg_addr == vic_pkg::OFS_SEL) begin
				sel_next = reg_wdata[7:0];
			end else if (reg_addr == vic_pkg::OFS_SRC_CFG) begin
				if (sel_reg < NSRC) begin
					// Only upper bits of the 8-bit field kept
					prio_next[sel_reg] = reg_wdata[7 -: vic_pkg::PRIO_BITS];
					en_next[sel_reg] = reg_wdata[vic_pkg::SRCCFG_EN_BIT];
				end
			end else if (reg_addr == vic_pkg::OFS_PEND_SET) begin
				if (reg_wdata[7:0] < NSRC)
					pend_next[reg_wdata[7:0]] = 1'b1;
			end else if (reg_addr == vic_pkg::OFS_PEND_CLR) begin
				if (reg_wdata[7:0] < NSRC)
					pend_next[reg_wdata[7:0]] = 1'b0;
			end
		end

		// Dispatch sequence
		case (st_reg)
			vic_pkg::ST_IDLE, vic_pkg::ST_RUN: begin
				// Request only while the global gate is open
				req_next = can_preempt && !ctrl_reg.gmask &&
					depth_reg < DEPTH[3:0];
				if (req_next)
					vec_next = vtbase_reg + slot_ofs(win.id, ctrl_reg.altmap);
				if (req_reg && cpu_irq_ack && can_preempt) begin
					take = 1'b1;
					req_next = 1'b0;
					pend_next[win.id] = 1'b0;
					act_next[win.id] = 1'b1;
					stk_id_next[depth_reg[2:0]] = cur_id_reg;
					stk_pr_next[depth_reg[2:0]] = run_pr_reg;
					depth_next = depth_reg + 4'h1;
					cur_id_next = win.id;
					run_pr_next = win.prio;
					stack_go_next = 1'b1;
					// SRAM table waits for stacking; flash overlaps
					st_next = vic_pkg::ST_STACK;
					cnt_next = ctrl_reg.tbl_sram ?
						vic_pkg::STACK_CYC + vic_pkg::FETCH_CYC
						: vic_pkg::STACK_CYC;
				end else if (st_reg == vic_pkg::ST_RUN && cpu_eoi) begin
					// Pop; a waiting request then tail-chains
					act_next[cur_id_reg] = 1'b0;
					depth_next = depth_reg - 4'h1;
					cur_id_next = stk_id_reg[depth_next[2:0]];
					run_pr_next = stk_pr_reg[depth_next[2:0]];
					if (depth_reg == 4'h1) begin
						st_next = vic_pkg::ST_IDLE;
						run_pr_next = vic_pkg::PRIO_IDLE;
					end
				end
			end
			vic_pkg::ST_STACK: begin
				req_next = 1'b0;
				cnt_next = cnt_reg - 4'h1;
				if (cnt_reg == 4'h1)
					st_next = vic_pkg::ST_RUN;
			end
			default: begin
				st_next = vic_pkg::ST_IDLE;
			end
		endcase

		// Rising edges latch regardless of enable; a new edge beats entry
		pend_next = pend_next | (irq_src & ~src_d_reg);

		// Register reads, answered the next cycle
		if (reg_rd) begin
			if (reg_addr == vic_pkg::OFS_CTRL) begin
				rdata_next[vic_pkg::CTRL_GMASK_BIT] = ctrl_reg.gmask;
				rdata_next[vic_pkg::CTRL_ALTMAP_BIT] = ctrl_reg.altmap;
				rdata_next[vic_pkg::CTRL_TBLSRAM_BIT] = ctrl_reg.tbl_sram;
				rdata_next[vic_pkg::CTRL_GROUP_LSB +: 2] = ctrl_reg.sub_bits;
			end else if (reg_addr == vic_pkg::OFS_STATUS) begin
				rdata_next[3:0] = depth_reg;
				rdata_next[15:8] = cur_id_reg;
				rdata_next[18:16] = run_pr_reg;
				rdata_next[19] = win.valid;
				rdata_next[31:24] = win.id;
			end else if (reg_addr == vic_pkg::OFS_VTBASE) begin
				rdata_next = vtbase_reg;
			end else if (reg_addr == vic_pkg::OFS_SEL) begin
				rdata_next[7:0] = sel_reg;
			end else if (reg_addr == vic_pkg::OFS_SRC_CFG) begin
				if (sel_reg < NSRC) begin
					rdata_next[7 -: vic_pkg::PRIO_BITS] = prio_reg[sel_reg];
					rdata_next[vic_pkg::SRCCFG_EN_BIT] = en_reg[sel_reg];
					rdata_next[9] = pend_reg[sel_reg];
					rdata_next[10] = act_reg[sel_reg];
				end
			end
		end

		// Context held across a tail chain while an eligible request waits
		in_h_next = (depth_next != 4'h0) ||
			(in_h_reg && win.valid && !ctrl_reg.gmask);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ctrl_reg <= '0;
			ctrl_reg.sub_bits <= vic_pkg::GROUP_RST;
			vtbase_reg <= vic_pkg::VTBASE_RST;
			sel_reg <= 8'h00;
			en_reg <= '0;
			pend_reg <= '0;
			act_reg <= '0;
			src_d_reg <= '0;
			for (int i = 0; i < NSRC; i++)
				prio_reg[i] <= 3'h0;
			for (int j = 0; j < DEPTH; j++) begin
				stk_id_reg[j] <= 8'h00;
				stk_pr_reg[j] <= vic_pkg::PRIO_IDLE;
			end
			st_reg <= vic_pkg::ST_IDLE;
			cnt_reg <= 4'h0;
			cur_id_reg <= 8'h00;
			depth_reg <= 4'h0;
			run_pr_reg <= vic_pkg::PRIO_IDLE;
			req_reg <= 1'b0;
			vec_reg <= 32'h00000000;
			rdata_reg <= 32'h00000000;
			stack_go_reg <= 1'b0;
			in_h_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			vtbase_reg <= vtbase_next;
			sel_reg <= sel_next;
			en_reg <= en_next;
			pend_reg <= pend_next;
			act_reg <= act_next;
			src_d_reg <= src_d_next;
			prio_reg <= prio_next;
			stk_id_reg <= stk_id_next;
			stk_pr_reg <= stk_pr_next;
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			cur_id_reg <= cur_id_next;
			depth_reg <= depth_next;
			run_pr_reg <= run_pr_next;
			req_reg <= req_next;
			vec_reg <= vec_next;
			rdata_reg <= rdata_next;
			stack_go_reg <= stack_go_next;
			in_h_reg <= in_h_next;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = rdata_reg;
	assign cpu_irq_req = req_reg;
	assign cpu_vector = vec_reg;
	assign cpu_irq_id = cur_id_reg;
	assign cpu_in_handler = in_h_reg;
	assign cpu_stack_go = stack_go_reg;

endmodule : vic_ctrl

/* tb/vic_ctrl_checker.sv */
// Checker: port-level properties of the interrupt controller
`timescale 1ns/1ps
module vic_ctrl_checker (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic cpu_irq_req,
	input wire logic [31:0] cpu_vector,
	input wire logic [7:0] cpu_irq_id,
	input wire logic cpu_irq_ack,
	input wire logic cpu_in_handler,
	input wire logic cpu_stack_go
);
	logic gm_reg;
	logic gm_next;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Shadow of the global mask, so blocking is judged at the pins
	always_comb begin
		gm_next = gm_reg;
		if (reg_wr && reg_addr == vic_pkg::OFS_CTRL) begin
			gm_next = reg_wdata[vic_pkg::CTRL_GMASK_BIT];
		end
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			gm_reg <= 1'b0;
		end else begin
			gm_reg <= gm_next;
		end
	end
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	a_stack_pulse: assert property (cpu_stack_go |=> !cpu_stack_go)
		else $error("stacking pulse longer than one cycle");
	a_stack_cause: assert property (cpu_stack_go |-> $past(cpu_irq_ack))
		else $error("stacking without acceptance");
	a_stack_nest: assert property (cpu_stack_go |-> cpu_in_handler)
		else $error("entry without handler context");
	a_enter_stack: assert property ($rose(cpu_in_handler) |-> cpu_stack_go)
		else $error("handler context without entry");
	a_vec_align: assert property (cpu_irq_req |-> cpu_vector[1:0] == 2'h0)
		else $error("vector not word aligned");
	a_gmask_block: assert property (gm_reg [*3] |-> !cpu_irq_req)
		else $error("request while globally masked");
	a_idle_id: assert property (!cpu_in_handler |-> cpu_irq_id == 8'h00)
		else $error("handler id outside handler context");
	cover property (cpu_stack_go && $past(cpu_in_handler));
	cover property ($fell(cpu_in_handler));
	cover property (gm_reg ##1 !gm_reg);
endmodule : vic_ctrl_checker
bind vic_ctrl vic_ctrl_checker i_chk (.clk_sys(clk_sys), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_irq_req(cpu_irq_req),
	.cpu_vector(cpu_vector), .cpu_irq_id(cpu_irq_id),
	.cpu_irq_ack(cpu_irq_ack), .cpu_in_handler(cpu_in_handler),
	.cpu_stack_go(cpu_stack_go));

/* tb/vic_core_model.sv */
// Processor core model: accepts requests, returns from handlers
`timescale 1ns/1ps
module vic_core_model (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic cpu_irq_req,
	input wire logic [31:0] cpu_vector,
	input wire logic [7:0] cpu_irq_id,
	input wire logic cpu_stack_go,
	input wire logic [3:0] ack_wait,
	input wire logic ret_go,
	output logic cpu_irq_ack,
	output logic cpu_eoi,
	output int n_taken,
	output logic [7:0] last_id,
	output logic [31:0] last_vec
);
	int wcnt;
	int hold;
	int run;
	logic ret_pend;
	// Hold-off after an ack stops a second ack on a stale request
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			{cpu_irq_ack, cpu_eoi, ret_pend} <= 3'h0;
			{n_taken, wcnt, hold, run} <= '0;
			last_id <= 8'h00;
			last_vec <= 32'h0;
		end else begin
			cpu_irq_ack <= 1'b0;
			cpu_eoi <= 1'b0;
			hold <= (hold > 0) ? hold - 1 : 0;
			wcnt <= cpu_irq_req ? wcnt + 1 : 0;
			if (cpu_irq_req && hold == 0 && wcnt >= ack_wait) begin
				cpu_irq_ack <= 1'b1;
				last_vec <= cpu_vector;
				hold <= 3;
				wcnt <= 0;
			end
			run <= cpu_stack_go ? 0 : run + 1;
			if (cpu_stack_go) begin
				n_taken <= n_taken + 1;
				last_id <= cpu_irq_id;
			end
			if (ret_go) begin
				ret_pend <= 1'b1;
			end
			// Return only after stacking and vector fetch are over
			if (ret_pend && run >= 8 && hold == 0 && !cpu_eoi) begin
				cpu_eoi <= 1'b1;
				ret_pend <= 1'b0;
			end
		end
	end
endmodule : vic_core_model

/* tb/tb.sv */
// Testbench for the vectored interrupt controller
`timescale 1ns/1ps
module tb;
	logic clk_sys, resetn, reg_wr, reg_rd, ret_go, ack, eoi, req, in_h, stk;
	logic [162:0] irq_src;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, vec, lvec, rd;
	logic [7:0] cid, lid;
	logic [3:0] ack_wait;
	int n_tk, seen, err_count, n_tests, age;
	vic_ctrl i_dut (.clk_sys(clk_sys), .resetn(resetn), .irq_src(irq_src),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_irq_req(req),
		.cpu_vector(vec), .cpu_irq_id(cid), .cpu_irq_ack(ack),
		.cpu_eoi(eoi), .cpu_in_handler(in_h), .cpu_stack_go(stk));
	vic_core_model i_core (.clk_sys(clk_sys), .resetn(resetn),
		.cpu_irq_req(req), .cpu_vector(vec), .cpu_irq_id(cid),
		.cpu_stack_go(stk), .ack_wait(ack_wait), .ret_go(ret_go),
		.cpu_irq_ack(ack), .cpu_eoi(eoi), .n_taken(n_tk),
		.last_id(lid), .last_vec(lvec));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Cycles since the last stacking pulse, for entry latency checks
	always @(posedge clk_sys) begin
		age <= stk ? 0 : age + 1;
	end
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rdr(input logic [11:0] a);
		@(posedge clk_sys);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask : rdr
	task automatic ctl(input logic g, a, s, input logic [1:0] sb);
		wr(vic_pkg::OFS_CTRL, {26'h0, sb, 1'b0, s, a, g});
	endtask : ctl
	task automatic cfg(input logic [7:0] id, input logic [2:0] p, input logic e);
		wr(vic_pkg::OFS_SEL, {24'h0, id});
		wr(vic_pkg::OFS_SRC_CFG, {23'h0, e, p, 5'h00});
	endtask : cfg
	task automatic pulse(input logic [162:0] m);
		@(posedge clk_sys);
		irq_src <= m;
		@(posedge clk_sys);
		irq_src <= '0;
	endtask : pulse
	function automatic logic [31:0] vx(input int id, input int sh);
		return 32'h00000400 + ((id + 16) << sh);
	endfunction : vx
	// Bounded wait for the next handler entry, then compare it
	task automatic take(input logic [7:0] id, input logic [31:0] v);
		for (int i = 0; i < 200 && n_tk <= seen; i++) @(negedge clk_sys);
		chk(n_tk > seen, "no handler entry");
		if (n_tk <= seen) tally_and_finish();
		seen++;
		chk(lid === id && lvec === v, "wrong handler id or vector");
	endtask : take
	task automatic none(input int n);
		repeat (n) @(negedge clk_sys);
		chk(n_tk == seen, "unexpected handler entry");
	endtask : none
	// A waiting preemptor is requested only once stacking and fetch end
	task automatic lat(input int n);
		for (int i = 0; i < 50 && req !== 1'b1; i++) @(negedge clk_sys);
		chk(req === 1'b1 && age == n, "wrong stacking latency");
	endtask : lat
	task automatic ret();
		@(posedge clk_sys);
		ret_go <= 1'b1;
		@(posedge clk_sys);
		ret_go <= 1'b0;
		for (int i = 0; i < 50 && eoi !== 1'b1; i++) @(negedge clk_sys);
		chk(eoi === 1'b1, "no return");
		if (eoi !== 1'b1) tally_and_finish();
		@(negedge clk_sys);
	endtask : ret
	task automatic s_vec();
		cfg(8'h05, 3'h2, 1'b1);
		pulse(163'h1 << 5);
		take(8'h05, vx(5, 3));
		ret();
		chk(in_h === 1'b0, "context not left");
	endtask : s_vec
	task automatic s_alt();
		ack_wait <= 4'h3;
		ctl(1'b0, 1'b1, 1'b1, 2'h0);
		cfg(8'ha2, 3'h1, 1'b1);
		cfg(8'ha1, 3'h0, 1'b1);
		pulse(163'h1 << 162);
		take(8'ha2, vx(162, 2));
		pulse(163'h1 << 161);
		lat(vic_pkg::STACK_CYC + vic_pkg::FETCH_CYC);
		take(8'ha1, vx(161, 2));
		ret();
		ret();
		ack_wait <= 4'h0;
		ctl(1'b0, 1'b0, 1'b0, 2'h0);
	endtask : s_alt
	task automatic s_clr();
		cfg(8'h07, 3'h2, 1'b0);
		wr(vic_pkg::OFS_SRC_CFG, 32'h0000005f);
		pulse(163'h1 << 7);
		none(30);
		rdr(vic_pkg::OFS_SRC_CFG);
		chk(rd[9] === 1'b1, "pending lost while disabled");
		chk(rd[7:0] === 8'h40, "unimplemented priority bits kept");
		wr(vic_pkg::OFS_PEND_CLR, 32'h7);
		cfg(8'h07, 3'h2, 1'b1);
		none(30);
	endtask : s_clr
	task automatic s_pre();
		cfg(8'h14, 3'h4, 1'b1);
		cfg(8'h15, 3'h1, 1'b1);
		pulse(163'h1 << 20);
		take(8'h14, vx(20, 3));
		pulse(163'h1 << 21);
		lat(vic_pkg::STACK_CYC);
		take(8'h15, vx(21, 3));
		ret();
		chk(in_h === 1'b1, "nesting lost");
		ret();
		chk(in_h === 1'b0, "context not left");
	endtask : s_pre
	// One preemption bit: prio 2 and prio 0 share a group
	task automatic s_sub();
		ctl(1'b0, 1'b0, 1'b0, 2'h2);
		cfg(8'h1e, 3'h2, 1'b1);
		cfg(8'h1d, 3'h0, 1'b1);
		cfg(8'h1f, 3'h0, 1'b1);
		pulse(163'h1 << 30);
		take(8'h1e, vx(30, 3));
		pulse((163'h1 << 29) | (163'h1 << 31));
		none(30);
		ret();
		chk(in_h === 1'b1, "context left with requests pending");
		take(8'h1d, vx(29, 3));
		ret();
		take(8'h1f, vx(31, 3));
		ret();
		ctl(1'b0, 1'b0, 1'b0, 2'h0);
	endtask : s_sub
	task automatic s_gm();
		ctl(1'b1, 1'b0, 1'b0, 2'h0);
		cfg(8'h28, 3'h3, 1'b1);
		wr(vic_pkg::OFS_PEND_SET, 32'h28);
		none(30);
		rdr(vic_pkg::OFS_SRC_CFG);
		chk(rd[8] === 1'b1, "source enable disturbed");
		ctl(1'b0, 1'b0, 1'b0, 2'h0);
		take(8'h28, vx(40, 3));
		ret();
	endtask : s_gm
	initial begin
		{resetn, reg_wr, reg_rd, ret_go, reg_addr, reg_wdata} = '0;
		{irq_src, ack_wait, seen, err_count, n_tests} = '0;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		ctl(1'b0, 1'b0, 1'b0, 2'h0);
		wr(vic_pkg::OFS_VTBASE, 32'h00000400);
		rdr(12'h01c);
		chk(rd === 32'h0, "reserved read not zero");
		s_vec();
		s_alt();
		s_clr();
		s_pre();
		s_sub();
		s_gm();
		tally_and_finish();
	end
endmodule : tb
